// *** common/sktl_pkg.sv ***
// Shared constants and types for the skip and timer load decoder
package sktl_pkg;
  // ****************************************
  // Opcode and sequencer state types
  // ****************************************
  typedef enum logic [2:0] {
    SKTL_OP_NONE,
    SKTL_OP_ZERO_MEM_BIT,
    SKTL_OP_CARRY_CLEAR,
    SKTL_OP_PORT_BIT_ZERO,
    SKTL_OP_LOAD_TIMER_ONE
  } sktl_op_t;

  typedef enum logic [1:0] {
    SKTL_ST_IDLE,
    SKTL_ST_SECOND,
    SKTL_ST_DONE
  } sktl_state_t;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int SKTL_NIBBLE_W = 4;
  localparam int SKTL_TIMER_W = 8;
  localparam int SKTL_PORT_W = 8;
  localparam int SKTL_SEL_W = 3;
  localparam int SKTL_BIT_SEL_W = 2;
  localparam int SKTL_TIMER_HI_LSB = 4;
  localparam logic [1:0] SKTL_PORT_BIT_WORDS = 2'h2;
  localparam logic [1:0] SKTL_SINGLE_WORDS = 2'h1;
  localparam logic [7:0] SKTL_TIMER_RST = 8'h00;
endpackage : sktl_pkg

// *** common/sktl_res_if.sv ***
// Result bundle from the condition evaluator to the decoder top
`timescale 1ns/10ps
`default_nettype none
interface sktl_res_if;
  logic skip_cond;
  logic load_timer;
  modport eval_mp (output skip_cond, output load_timer);
  modport top_mp (input skip_cond, input load_timer);
endinterface : sktl_res_if
`default_nettype wire

// *** design/sktl_cond_eval.sv ***
// Skip condition evaluation for the decoded instruction
`timescale 1ns/10ps
`default_nettype none
module sktl_cond_eval
  import sktl_pkg::*;
(
  input wire sktl_op_t op_in,
  input wire logic [SKTL_NIBBLE_W-1:0] mem_nibble_in,
  input wire logic [SKTL_BIT_SEL_W-1:0] bit_sel_in,
  input wire logic carry_in,
  input wire logic [SKTL_PORT_W-1:0] port_in,
  input wire logic [SKTL_SEL_W-1:0] port_sel_in,
  sktl_res_if.eval_mp res
);
  wire mem_bit_zero;
  wire port_bit_zero;
  assign mem_bit_zero = ~mem_nibble_in[bit_sel_in];
  assign port_bit_zero = ~port_in[port_sel_in];
  assign res.skip_cond = (op_in == SKTL_OP_ZERO_MEM_BIT) ? mem_bit_zero :
                         (op_in == SKTL_OP_CARRY_CLEAR) ? ~carry_in :
                         (op_in == SKTL_OP_PORT_BIT_ZERO) ? port_bit_zero :
                         1'b0;
  assign res.load_timer = (op_in == SKTL_OP_LOAD_TIMER_ONE);
endmodule : sktl_cond_eval
`default_nettype wire

// *** design/sktl_decoder.sv ***
// Execution unit for three skip instructions and the timer one load
`timescale 1ns/10ps
`default_nettype none
module sktl_decoder
  import sktl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire sktl_op_t op_in,
  input wire logic [SKTL_NIBBLE_W-1:0] mem_nibble_in,
  input wire logic [SKTL_BIT_SEL_W-1:0] bit_sel_in,
  input wire logic carry_in,
  input wire logic [SKTL_PORT_W-1:0] sink_port_pins_in,
  input wire logic [SKTL_SEL_W-1:0] port_bit_selector_in,
  input wire logic [SKTL_NIBBLE_W-1:0] upper_operand_reg_in,
  input wire logic [SKTL_NIBBLE_W-1:0] lower_nibble_source_in,
  output logic busy_out,
  output logic done_out,
  output logic skip_next_out,
  output logic [1:0] words_used_out,
  output logic carry_out,
  output logic [SKTL_TIMER_W-1:0] timer_one_count_out,
  output logic [SKTL_TIMER_W-1:0] timer_one_reload_out
);
  // ****************************************
  // Pin synchroniser for the sink port
  // ****************************************
  logic [SKTL_PORT_W-1:0] port_meta_ff;
  logic [SKTL_PORT_W-1:0] port_sync_ff;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_meta_ff <= 8'h00;
      port_sync_ff <= 8'h00;
    end else begin
      port_meta_ff <= sink_port_pins_in;
      port_sync_ff <= port_meta_ff;
    end
  end

  // ****************************************
  // Condition evaluation
  // ****************************************
  sktl_res_if res_if ();
  sktl_state_t state_ff;
  sktl_state_t nxt_state;
  sktl_op_t op_ff;
  sktl_op_t eval_op;
  wire take_op;
  wire second_cycle;
  assign second_cycle = (state_ff == SKTL_ST_SECOND);
  // Start is refused while the port skip holds its second cycle
  assign take_op = !second_cycle && start_in;
  // Issue cycle evaluates the new opcode, the port second cycle the held one
  always_comb begin
    if (take_op) begin
      eval_op = op_in;
    end else begin
      eval_op = op_ff;
    end
  end
  sktl_cond_eval u_eval (
    .op_in(eval_op),
    .mem_nibble_in(mem_nibble_in),
    .bit_sel_in(bit_sel_in),
    .carry_in(carry_in),
    .port_in(port_sync_ff),
    .port_sel_in(port_bit_selector_in),
    .res(res_if.eval_mp)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Port skip needs a second cycle; the synchronised pins are sampled there
  logic skip_ff;
  logic [1:0] words_ff;
  logic done_ff;
  logic [SKTL_TIMER_W-1:0] count_ff;
  logic [SKTL_TIMER_W-1:0] reload_ff;
  wire op_is_port;
  wire issue_port;
  wire issue_single;
  wire issue_load;
  wire nxt_done;
  wire nxt_skip;
  wire [1:0] nxt_words;
  wire [SKTL_TIMER_W-1:0] load_val;
  assign op_is_port = (op_in == SKTL_OP_PORT_BIT_ZERO);
  assign issue_port = take_op && op_is_port;
  assign issue_single = take_op && !op_is_port;
  assign issue_load = take_op && res_if.load_timer;
  assign nxt_done = issue_single || second_cycle;
  // One result register serves the issue cycle and the port second cycle
  assign nxt_skip = nxt_done ? res_if.skip_cond : skip_ff;
  assign nxt_words = issue_port ? SKTL_PORT_BIT_WORDS :
                     issue_single ? SKTL_SINGLE_WORDS : words_ff;
  assign load_val = {upper_operand_reg_in, lower_nibble_source_in};

  always_comb begin
    case (state_ff)
      SKTL_ST_IDLE, SKTL_ST_DONE: begin
        if (issue_port) begin
          nxt_state = SKTL_ST_SECOND;
        end else if (issue_single) begin
          nxt_state = SKTL_ST_DONE;
        end else begin
          nxt_state = SKTL_ST_IDLE;
        end
      end
      SKTL_ST_SECOND: nxt_state = SKTL_ST_DONE;
      default: nxt_state = SKTL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= SKTL_ST_IDLE;
      op_ff <= SKTL_OP_NONE;
    end else begin
      state_ff <= nxt_state;
      op_ff <= eval_op;
    end
  end

  // Skip moves at a single-cycle issue or the port second cycle, words at any issue; done is high only in the cycle after a single-cycle issue or the second cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      skip_ff <= 1'b0;
      words_ff <= 2'h0;
      done_ff <= 1'b0;
    end else begin
      skip_ff <= nxt_skip;
      words_ff <= nxt_words;
      done_ff <= nxt_done;
    end
  end

  // ****************************************
  // Timer one load
  // ****************************************
  // Count and reload take the same byte; counting down is not modelled here
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_ff <= SKTL_TIMER_RST;
      reload_ff <= SKTL_TIMER_RST;
    end else if (issue_load) begin
      count_ff <= load_val;
      reload_ff <= load_val;
    end
  end

  assign busy_out = (state_ff == SKTL_ST_SECOND);
  assign done_out = done_ff;
  assign skip_next_out = skip_ff;
  assign words_used_out = words_ff;
  assign carry_out = carry_in;
  assign timer_one_count_out = count_ff;
  assign timer_one_reload_out = reload_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_port_two_cycles: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_PORT_BIT_ZERO) |=> busy_out ##1
    (done_out && words_used_out == 2'h2)) else $error("port skip not two cycles");
  a_carry_skip_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_CARRY_CLEAR) |=>
    (skip_next_out == !$past(carry_in))) else $error("carry skip wrong");
  a_carry_kept: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    carry_out == carry_in) else $error("carry altered");
  a_mem_bit_skip: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_ZERO_MEM_BIT) |=>
    (skip_next_out == !$past(mem_nibble_in[bit_sel_in]))) else $error("mem skip wrong");
  a_port_bit_skip: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_out |=> (skip_next_out == !$past(port_sync_ff[port_bit_selector_in])))
    else $error("port skip wrong");
  a_timer_load_val: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_LOAD_TIMER_ONE) |=>
    (timer_one_count_out == {$past(upper_operand_reg_in), $past(lower_nibble_source_in)}
     && timer_one_reload_out == timer_one_count_out)) else $error("timer load wrong");
  a_timer_no_skip: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_LOAD_TIMER_ONE) |=>
    (!skip_next_out && done_out && words_used_out == 2'h1)) else $error("timer load skip");
  a_single_done: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_ZERO_MEM_BIT) |=> (done_out && !busy_out))
    else $error("mem skip not one cycle");
  a_busy_refuses: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_out |=> (!busy_out && $stable(timer_one_count_out) && $stable(words_used_out)))
    else $error("start taken while busy");
  a_port_words_held: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_out |-> (words_used_out == 2'h2)) else $error("port skip word count wrong");
  a_port_skip_late: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_in && !busy_out && op_in == SKTL_OP_PORT_BIT_ZERO) |=> $stable(skip_next_out))
    else $error("port skip result too early");
  a_timer_pair: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    timer_one_count_out == timer_one_reload_out) else $error("count and reload differ");
  a_timer_held: assert property (
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !(start_in && !busy_out && op_in == SKTL_OP_LOAD_TIMER_ONE) |=>
    $stable(timer_one_count_out)) else $error("timer changed without load");
endmodule : sktl_decoder
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the skip and timer load decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sktl_pkg::*;
  ;
  typedef struct {sktl_op_t op; logic [3:0] mem; logic [1:0] j; logic cy;
    logic [7:0] pins; logic [2:0] sel; logic [7:0] tmr; logic skip;} sktl_tb_row_t;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start_in = 1'b0;
  sktl_op_t op_in = SKTL_OP_NONE;
  logic [3:0] mem_in = 4'h0;
  logic [1:0] jsel_in = 2'h0;
  logic cy_in = 1'b0;
  logic [7:0] pins_in = 8'h00;
  logic [2:0] psel_in = 3'h0;
  logic [7:0] tmr_in = 8'h00;
  logic busy, done, skip, cy_o;
  logic [1:0] words;
  logic [7:0] cnt, rld, exp_tmr;
  int bad_count = 0;
  int check_count = 0;
  sktl_tb_row_t rows [12] = '{
    '{SKTL_OP_ZERO_MEM_BIT, 4'hB, 2'h2, 1'b1, 8'h00, 3'h0, 8'h00, 1'b1},
    '{SKTL_OP_ZERO_MEM_BIT, 4'h8, 2'h3, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0},
    '{SKTL_OP_ZERO_MEM_BIT, 4'hE, 2'h0, 1'b1, 8'h00, 3'h0, 8'h00, 1'b1},
    '{SKTL_OP_CARRY_CLEAR, 4'h0, 2'h0, 1'b0, 8'h00, 3'h0, 8'h00, 1'b1},
    '{SKTL_OP_CARRY_CLEAR, 4'h0, 2'h0, 1'b1, 8'h00, 3'h0, 8'h00, 1'b0},
    '{SKTL_OP_PORT_BIT_ZERO, 4'h0, 2'h0, 1'b1, 8'h7F, 3'h7, 8'h00, 1'b1},
    '{SKTL_OP_PORT_BIT_ZERO, 4'h0, 2'h0, 1'b0, 8'h80, 3'h7, 8'h00, 1'b0},
    '{SKTL_OP_PORT_BIT_ZERO, 4'h0, 2'h0, 1'b1, 8'hFE, 3'h0, 8'h00, 1'b1},
    '{SKTL_OP_LOAD_TIMER_ONE, 4'h0, 2'h0, 1'b1, 8'h00, 3'h0, 8'hA5, 1'b0},
    '{SKTL_OP_LOAD_TIMER_ONE, 4'h0, 2'h0, 1'b0, 8'h00, 3'h0, 8'h3C, 1'b0},
    '{SKTL_OP_NONE, 4'h0, 2'h0, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0},
    '{SKTL_OP_ZERO_MEM_BIT, 4'hD, 2'h1, 1'b0, 8'h00, 3'h0, 8'h00, 1'b1}};
  sktl_decoder sktl_decoder_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .start_in(start_in), .op_in(op_in), .mem_nibble_in(mem_in), .bit_sel_in(jsel_in),
    .carry_in(cy_in), .sink_port_pins_in(pins_in), .port_bit_selector_in(psel_in),
    .upper_operand_reg_in(tmr_in[7:4]), .lower_nibble_source_in(tmr_in[3:0]),
    .busy_out(busy), .done_out(done), .skip_next_out(skip), .words_used_out(words),
    .carry_out(cy_o), .timer_one_count_out(cnt), .timer_one_reload_out(rld));
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Pins are set three edges early so the synchroniser has settled
  task automatic run_row(input sktl_tb_row_t r);
    int n;
    logic port;
    port = (r.op == SKTL_OP_PORT_BIT_ZERO);
    @(posedge clk_sys_in);
    op_in <= r.op;
    mem_in <= r.mem;
    jsel_in <= r.j;
    cy_in <= r.cy;
    pins_in <= r.pins;
    psel_in <= r.sel;
    tmr_in <= r.tmr;
    repeat (3) @(posedge clk_sys_in);
    start_in <= 1'b1;
    n = 0;
    // n counts edges from the one that takes the request
    do begin
      @(posedge clk_sys_in);
      if (n == 0) start_in <= 1'b0;
      #1;
      n++;
      if (n == 1) check("busy", {7'h00, busy}, {7'h00, port});
    end while (done !== 1'b1 && n < 8);
    if (r.op == SKTL_OP_LOAD_TIMER_ONE) exp_tmr = r.tmr;
    check("latency", 8'(n), port ? 8'h02 : 8'h01);
    check("skip", {7'h00, skip}, {7'h00, r.skip});
    check("words", {6'h00, words}, port ? 8'h02 : 8'h01);
    check("carry", {7'h00, cy_o}, {7'h00, r.cy});
    check("count", cnt, exp_tmr);
    check("reload", rld, exp_tmr);
    @(posedge clk_sys_in);
    #1;
    check("done_pulse", {7'h00, done}, 8'h00);
  endtask : run_row
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_tmr = 8'h00;
    repeat (20) @(posedge clk_sys_in);
    check("rst_busy", {7'h00, busy}, 8'h00);
    check("rst_count", cnt, 8'h00);
    check("rst_reload", rld, 8'h00);
    check("rst_words", {6'h00, words}, 8'h00);
    check("rst_done", {7'h00, done}, 8'h00);
    check("rst_skip", {7'h00, skip}, 8'h00);
    rst_b_in <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Request during the port skip second cycle must be ignored
    @(posedge clk_sys_in);
    op_in <= SKTL_OP_PORT_BIT_ZERO;
    pins_in <= 8'h01;
    psel_in <= 3'h0;
    repeat (3) @(posedge clk_sys_in);
    start_in <= 1'b1;
    @(posedge clk_sys_in);
    op_in <= SKTL_OP_LOAD_TIMER_ONE;
    tmr_in <= 8'hFF;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    #1;
    check("busy_done", {7'h00, done}, 8'h01);
    check("busy_skip", {7'h00, skip}, 8'h00);
    check("busy_count", cnt, exp_tmr);
    @(posedge clk_sys_in);
    #1;
    check("busy_no_done", {7'h00, done}, 8'h00);
    check("busy_reload", rld, exp_tmr);
    $display("refused request test done");
    // Reset in mid-run clears the results, then a load must still work
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    check("mid_count", cnt, 8'h00);
    check("mid_reload", rld, 8'h00);
    check("mid_words", {6'h00, words}, 8'h00);
    check("mid_done", {7'h00, done}, 8'h00);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    exp_tmr = 8'h00;
    run_row(rows[8]);
    $display("mid-run reset test done");
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    bad_count++;
    $display("[FAIL] watchdog expired");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
